// File: rtl/tmr_pkg.sv
// Purpose: shared constants for the 16-bit timer core and its controller
// Assumes: 8-bit byte bus between the two ends, one clock
// Notes: byte addresses on the timer bus, word offsets on AHB-Lite
package tmr_pkg;
   localparam logic [3:0] A_CNT_LO = 4'h0;
   localparam logic [3:0] A_CNT_HI = 4'h1;
   localparam logic [3:0] A_CMPA_LO = 4'h2;
   localparam logic [3:0] A_CMPA_HI = 4'h3;
   localparam logic [3:0] A_CMPB_LO = 4'h4;
   localparam logic [3:0] A_CMPB_HI = 4'h5;
   localparam logic [3:0] A_CMPC_LO = 4'h6;
   localparam logic [3:0] A_CMPC_HI = 4'h7;
   localparam logic [3:0] A_CAP_LO = 4'h8;
   localparam logic [3:0] A_CAP_HI = 4'h9;
   localparam logic [3:0] A_CTRL_A = 4'ha;
   localparam logic [3:0] A_CTRL_B = 4'hb;
   localparam logic [3:0] A_CTRL_C = 4'hc;
   localparam logic [3:0] A_FLAGS = 4'hd;
   localparam logic [3:0] A_MASK = 4'he;
   // Field positions
   localparam int B_WM_LO = 0;
   localparam int B_CMPC_MODE = 2;
   localparam int B_WM_HI = 3;
   localparam int B_FORCE = 5;
   localparam int B_TOV = 0;
   localparam int B_MATCH = 1;
   // Limits
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   // Controller AHB-Lite word offsets
   localparam logic [7:0] H_CMD = 8'h00;
   localparam logic [7:0] H_WDATA = 8'h04;
   localparam logic [7:0] H_RDATA = 8'h08;
   localparam logic [7:0] H_STATUS = 8'h0c;
   localparam int B_CMD_WR = 4;
   localparam int B_CMD_WIDE = 5;
   localparam int B_ST_DONE = 0;
   localparam int B_ST_BUSY = 1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
   typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_SAMPLE} tmr_hstate_t;
endpackage

// File: rtl/tmr_bus_if.sv
// Purpose: byte bus between timer controller and timer core
// Assumes: one strobe cycle per access, read data one cycle later
// Notes: no clocking block; both ends share hclk
`timescale 1ns/1ns
interface tmr_bus_if;
   logic [3:0] addr;
   logic wr;
   logic rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport dev (input addr, input wr, input rd, input wdata, output rdata);
   modport host (output addr, output wr, output rd, output wdata, input rdata);
endinterface

// File: rtl/tmr_dev.sv
// Purpose: 16-bit up/down timer core with shared high-byte holding register
// Assumes: byte bus from the controller on the same clock; prescaler ticks on hclk
// Notes: compare outputs, capture events and noise filter live elsewhere
// Contract
// - Sixteen-bit registers move as two byte accesses
// - One shared high-byte holding register
// - Low-byte write loads all sixteen bits
// - Low-byte read copies high byte to holding
// - Compare reads bypass the holding register
// - Software writes high first, reads low first
// - Software masks interrupts around two-byte transfers
// - Holding register survives low-byte writes
// - Clock select picks internal or external tick
// - Select zero stops counter, access still works
// - CPU count write beats counter operations
// - Up/down counter steps by one or clears
// - Top and bottom indications driven
// - High count location maps to holding register
// - Each tick clears, increments or decrements
// - Four-bit wave mode split across A/B
// - Overflow flag set per mode, can interrupt
// - Legacy mode bits are wave mode low bits
// - Control C force bits; third compare channel
// - Avoid count writes in some running modes
// - Bottom is zero, maximum is all ones
// - Top fixed, compare A or capture
`timescale 1ns/1ns
module tmr_dev
   import tmr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   tmr_bus_if.dev bus,
   input wire logic [3:0] presc_tick,
   input wire logic ext_pin,
   output logic [15:0] count_value,
   output logic count_down,
   output logic count_top,
   output logic count_bottom,
   output logic [3:0] wave_mode,
   output logic [2:0] cmp_match,
   output logic [2:0] force_cmp,
   output logic [1:0] cmp_c_out_mode,
   output logic irq
);
   logic [7:0] hold_ff;
   logic [15:0] cnt_ff;
   logic [15:0] cmp_ff [3];
   logic [15:0] cap_ff;
   logic [7:0] ctrl_a_ff;
   logic [7:0] ctrl_b_ff;
   logic [3:0] flags_ff;
   logic [3:0] mask_ff;
   logic [7:0] rdata_ff;
   logic dir_ff;
   logic top_ff;
   logic bottom_ff;
   logic [2:0] match_ff;
   logic [2:0] force_ff;
   logic irq_ff;
   logic ext_s1_ff;
   logic ext_s2_ff;
   logic ext_s3_ff;

   // Top value per wave mode
   function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] oa, input logic [15:0] ic);
      case (m)
         4'h1, 4'h5: top_of = TOP_8BIT;
         4'h2, 4'h6: top_of = TOP_9BIT;
         4'h3, 4'h7: top_of = TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf: top_of = oa;
         4'h8, 4'ha, 4'hc, 4'he: top_of = ic;
         default: top_of = CNT_MAX;
      endcase
   endfunction

   function automatic logic dual_slope(input logic [3:0] m);
      dual_slope = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   endfunction

   function automatic logic is_hi(input logic [3:0] a);
      is_hi = (a == A_CNT_HI) || (a == A_CMPA_HI) || (a == A_CMPB_HI) ||
              (a == A_CMPC_HI) || (a == A_CAP_HI);
   endfunction

   wire [3:0] wm = {ctrl_b_ff[B_WM_HI+1:B_WM_HI], ctrl_a_ff[B_WM_LO+1:B_WM_LO]};
   wire [2:0] csel = ctrl_b_ff[2:0];
   wire ext_rise = ext_s2_ff & ~ext_s3_ff;
   wire ext_fall = ~ext_s2_ff & ext_s3_ff;
   wire sel_presc = (csel >= 3'h2) && (csel <= 3'h5);
   wire [1:0] presc_idx = 2'(csel - 3'h2);
   wire tick = (csel == 3'h1) || (sel_presc && presc_tick[presc_idx]) ||
               ((csel == 3'h6) && ext_fall) || ((csel == 3'h7) && ext_rise);
   wire [15:0] top_val = top_of(wm, cmp_ff[0], cap_ff);
   wire dual = dual_slope(wm);
   wire wr_cnt_lo = bus.wr && (bus.addr == A_CNT_LO);
   wire rd_cnt_lo = bus.rd && (bus.addr == A_CNT_LO);
   wire rd_cap_lo = bus.rd && (bus.addr == A_CAP_LO);
   wire wr_hi = bus.wr && is_hi(bus.addr);
   wire [15:0] wr_word = {hold_ff, bus.wdata};
   wire cap_top_mode = (wm == 4'h8) || (wm == 4'ha) || (wm == 4'hc) || (wm == 4'he);
   wire at_top = (cnt_ff == top_val);
   wire at_bottom = (cnt_ff == CNT_BOTTOM);
   wire ctc_like = (wm == 4'h0) || (wm == 4'h4) || (wm == 4'hc);

   logic [15:0] nxt_cnt;
   logic nxt_dir;
   always_comb
   begin
      nxt_cnt = cnt_ff;
      nxt_dir = dir_ff;
      if (wr_cnt_lo)
      begin
         nxt_cnt = wr_word;
      end
      else if (tick)
      begin
         if (dual)
         begin
            if (!dir_ff && at_top)
            begin
               nxt_dir = 1'b1;
               nxt_cnt = cnt_ff - 16'h0001;
            end
            else if (dir_ff && at_bottom)
            begin
               nxt_dir = 1'b0;
               nxt_cnt = cnt_ff + 16'h0001;
            end
            else
            begin
               nxt_cnt = dir_ff ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
            end
         end
         else
         begin
            nxt_dir = 1'b0;
            nxt_cnt = at_top ? CNT_BOTTOM : cnt_ff + 16'h0001;
         end
      end
   end

   // Overflow: max in normal/clear modes, top in fast, bottom in dual slope
   wire tov_hit = tick && !wr_cnt_lo &&
                  (dual ? (dir_ff && at_bottom) : (ctc_like ? (cnt_ff == CNT_MAX) : at_top));
   logic [2:0] match_hit;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_match
         assign match_hit[gi] = tick && (cnt_ff == cmp_ff[gi]);
      end
   endgenerate
   wire [3:0] flag_set = {match_hit, tov_hit};
   wire [3:0] flag_clr = (bus.wr && (bus.addr == A_FLAGS)) ? bus.wdata[3:0] : 4'h0;
   // Set wins so an event in the clearing cycle is kept
   wire [3:0] nxt_flags = (flags_ff & ~flag_clr) | flag_set;

   logic [7:0] nxt_hold;
   logic [7:0] rd_byte;
   always_comb
   begin
      nxt_hold = hold_ff;
      if (wr_hi)
         nxt_hold = bus.wdata;
      else if (rd_cnt_lo)
         nxt_hold = cnt_ff[15:8];
      else if (rd_cap_lo)
         nxt_hold = cap_ff[15:8];
      case (bus.addr)
         A_CNT_LO: rd_byte = cnt_ff[7:0];
         A_CNT_HI: rd_byte = hold_ff;
         A_CMPA_LO: rd_byte = cmp_ff[0][7:0];
         A_CMPA_HI: rd_byte = cmp_ff[0][15:8];
         A_CMPB_LO: rd_byte = cmp_ff[1][7:0];
         A_CMPB_HI: rd_byte = cmp_ff[1][15:8];
         A_CMPC_LO: rd_byte = cmp_ff[2][7:0];
         A_CMPC_HI: rd_byte = cmp_ff[2][15:8];
         A_CAP_LO: rd_byte = cap_ff[7:0];
         A_CAP_HI: rd_byte = hold_ff;
         A_CTRL_A: rd_byte = ctrl_a_ff;
         A_CTRL_B: rd_byte = ctrl_b_ff;
         A_FLAGS: rd_byte = {4'h0, flags_ff};
         A_MASK: rd_byte = {4'h0, mask_ff};
         default: rd_byte = RST_BYTE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_s3_ff <= 1'b0;
      end
      else
      begin
         ext_s1_ff <= ext_pin;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hold_ff <= RST_BYTE;
         cnt_ff <= RST_WORD;
         dir_ff <= 1'b0;
         ctrl_a_ff <= RST_BYTE;
         ctrl_b_ff <= RST_BYTE;
         rdata_ff <= RST_BYTE;
      end
      else
      begin
         hold_ff <= nxt_hold;
         cnt_ff <= nxt_cnt;
         dir_ff <= nxt_dir;
         if (bus.wr && (bus.addr == A_CTRL_A))
            ctrl_a_ff <= bus.wdata;
         if (bus.wr && (bus.addr == A_CTRL_B))
            ctrl_b_ff <= bus.wdata;
         if (bus.rd)
            rdata_ff <= rd_byte;
      end
   end

   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_cmp
         wire [3:0] lo_addr = 4'(A_CMPA_LO + 4'(2 * gi));
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               cmp_ff[gi] <= RST_WORD;
            else if (bus.wr && (bus.addr == lo_addr))
               cmp_ff[gi] <= wr_word;
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cap_ff <= RST_WORD;
         flags_ff <= 4'h0;
         mask_ff <= 4'h0;
         force_ff <= 3'h0;
      end
      else
      begin
         // Capture register is writable only while it defines top
         if (bus.wr && (bus.addr == A_CAP_LO) && cap_top_mode)
            cap_ff <= wr_word;
         flags_ff <= nxt_flags;
         if (bus.wr && (bus.addr == A_MASK))
            mask_ff <= bus.wdata[3:0];
         // Force bits are strobes and read back as zero
         force_ff <= (bus.wr && (bus.addr == A_CTRL_C)) ? bus.wdata[B_FORCE+2:B_FORCE] : 3'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         top_ff <= 1'b0;
         bottom_ff <= 1'b1;
         match_ff <= 3'h0;
         irq_ff <= 1'b0;
      end
      else
      begin
         top_ff <= (nxt_cnt == top_val);
         bottom_ff <= (nxt_cnt == CNT_BOTTOM);
         match_ff <= match_hit;
         irq_ff <= |(nxt_flags & mask_ff);
      end
   end

   assign bus.rdata = rdata_ff;
   assign count_value = cnt_ff;
   assign count_down = dir_ff;
   assign count_top = top_ff;
   assign count_bottom = bottom_ff;
   assign wave_mode = {ctrl_b_ff[B_WM_HI+1:B_WM_HI], ctrl_a_ff[B_WM_LO+1:B_WM_LO]};
   assign cmp_match = match_ff;
   assign force_cmp = force_ff;
   assign cmp_c_out_mode = ctrl_a_ff[B_CMPC_MODE+1:B_CMPC_MODE];
   assign irq = irq_ff;
endmodule

// File: rtl/tmr_host.sv
// Purpose: AHB-Lite controller issuing byte or 16-bit accesses to the timer core
// Assumes: zero-wait AHB-Lite slave, single word transfers
// Notes: a 16-bit sequence runs in hardware, nothing can split it
`timescale 1ns/1ns
module tmr_host
   import tmr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   tmr_bus_if.host bus
);
   tmr_hstate_t state_ff;
   logic [5:0] cmd_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic done_ff;
   logic step_ff;
   logic dp_wr_ff;
   logic [7:0] dp_addr_ff;
   logic [31:0] hrdata_ff;
   logic [3:0] baddr_ff;
   logic bwr_ff;
   logic brd_ff;
   logic [7:0] bwdata_ff;

   // Wide write: high then low; wide read: low then high
   function automatic logic [3:0] step_addr(input logic [5:0] c, input logic s);
      if (!c[B_CMD_WIDE])
         step_addr = c[3:0];
      else
         step_addr = {c[3:1], c[B_CMD_WR] ^ s};
   endfunction

   wire ap_take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == 3'h2);
   wire busy = (state_ff != ST_IDLE);
   wire wr_cmd = dp_wr_ff && (dp_addr_ff == H_CMD);
   wire start = wr_cmd && !busy;
   wire clr_done = dp_wr_ff && (dp_addr_ff == H_STATUS) && hwdata[B_ST_DONE];
   wire [5:0] go_cmd = start ? hwdata[5:0] : cmd_ff;
   wire more = cmd_ff[B_CMD_WIDE] && !step_ff;
   wire issue = start || ((state_ff == ST_SAMPLE) && more);
   wire nxt_step = start ? 1'b0 : 1'b1;
   wire [3:0] issue_addr = step_addr(go_cmd, nxt_step);
   wire [7:0] wide_byte = issue_addr[0] ? wdata_ff[15:8] : wdata_ff[7:0];
   wire finish = (state_ff == ST_SAMPLE) && !more;
   wire [31:0] rd_word = (haddr[7:0] == H_CMD) ? {26'h0, cmd_ff} :
                         (haddr[7:0] == H_WDATA) ? {16'h0, wdata_ff} :
                         (haddr[7:0] == H_RDATA) ? {16'h0, rdata_ff} :
                         (haddr[7:0] == H_STATUS) ? {30'h0, busy, done_ff} : 32'h0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_ff <= 1'b0;
         dp_addr_ff <= 8'h00;
         hrdata_ff <= 32'h0;
         wdata_ff <= 16'h0;
      end
      else
      begin
         dp_wr_ff <= ap_take && hwrite;
         dp_addr_ff <= haddr[7:0];
         if (ap_take && !hwrite)
            hrdata_ff <= rd_word;
         if (dp_wr_ff && (dp_addr_ff == H_WDATA) && !busy)
            wdata_ff <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_ff <= ST_IDLE;
         cmd_ff <= 6'h0;
         step_ff <= 1'b0;
         rdata_ff <= 16'h0;
         done_ff <= 1'b0;
         baddr_ff <= 4'h0;
         bwr_ff <= 1'b0;
         brd_ff <= 1'b0;
         bwdata_ff <= 8'h00;
      end
      else
      begin
         cmd_ff <= go_cmd;
         bwr_ff <= issue && go_cmd[B_CMD_WR];
         brd_ff <= issue && !go_cmd[B_CMD_WR];
         if (issue)
         begin
            step_ff <= nxt_step;
            baddr_ff <= issue_addr;
            bwdata_ff <= go_cmd[B_CMD_WIDE] ? wide_byte : wdata_ff[7:0];
         end
         case (state_ff)
            ST_IDLE: state_ff <= start ? ST_STROBE : ST_IDLE;
            ST_STROBE: state_ff <= ST_SAMPLE;
            ST_SAMPLE: state_ff <= more ? ST_STROBE : ST_IDLE;
            default: state_ff <= ST_IDLE;
         endcase
         if ((state_ff == ST_SAMPLE) && !cmd_ff[B_CMD_WR])
         begin
            if (cmd_ff[B_CMD_WIDE] && step_ff)
               rdata_ff[15:8] <= bus.rdata;
            else
               rdata_ff[7:0] <= bus.rdata;
         end
         // Completion wins over a clear in the same cycle
         done_ff <= finish || (done_ff && !clr_done) || (done_ff && start);
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY[0];
   assign hrdata = hrdata_ff;
   assign bus.addr = baddr_ff;
   assign bus.wr = bwr_ff;
   assign bus.rd = brd_ff;
   assign bus.wdata = bwdata_ff;
endmodule

// File: bench/tmr_bus_checker.sv
// Purpose: concurrent checks on the timer byte bus
// Assumes: one clock; count value seen beside the bus
// Notes: holding and control bytes are shadowed here
`timescale 1ns/1ns
module tmr_bus_checker
   import tmr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic [15:0] count_value
);
   logic [7:0] hold_ff;
   logic [7:0] ctla_ff;
   logic [7:0] ctlb_ff;
   wire logic hi_wr = wr && addr[0] && (addr <= A_CAP_HI);
   wire logic cnt_wr = wr && (addr == A_CNT_LO);
   wire logic [7:0] cnt_lo = count_value[7:0];
   wire logic [3:0] wm = {ctlb_ff[4:3], ctla_ff[1:0]};
   wire logic stopped = (ctlb_ff[2:0] == 3'h0);
   wire logic run0 = (ctlb_ff[2:0] == 3'h1) && (wm == 4'h0);
   wire logic run5 = (ctlb_ff[2:0] == 3'h1) && (wm == 4'h5);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hold_ff <= RST_BYTE;
         ctla_ff <= RST_BYTE;
         ctlb_ff <= RST_BYTE;
      end
      else
      begin
         if (hi_wr)
            hold_ff <= wdata;
         else if (rd && (addr == A_CNT_LO))
            hold_ff <= count_value[15:8];
         if (wr && (addr == A_CTRL_A))
            ctla_ff <= wdata;
         if (wr && (addr == A_CTRL_B))
            ctlb_ff <= wdata;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_lo_write;
      cnt_wr |=> count_value == {$past(hold_ff), $past(wdata)};
   endproperty
   a_lo_write: assert property (p_lo_write)
      else $error("count low write did not load both bytes");
   property p_lo_read;
      rd && (addr == A_CNT_LO) |=> rdata == $past(cnt_lo);
   endproperty
   a_lo_read: assert property (p_lo_read)
      else $error("count low read wrong");
   property p_hi_read;
      rd && (addr == A_CNT_HI) |=> rdata == $past(hold_ff);
   endproperty
   a_hi_read: assert property (p_hi_read)
      else $error("count high read not from holding byte");
   property p_stop;
      stopped && $past(stopped) && !cnt_wr |=> $stable(count_value);
   endproperty
   a_stop: assert property (p_stop)
      else $error("count moved while stopped");
   property p_step;
      run0 && $past(run0) && !cnt_wr |=> count_value == $past(count_value) + 16'h1;
   endproperty
   a_step: assert property (p_step)
      else $error("count did not step by one");
   property p_top5;
      run5 && $past(run5) && !cnt_wr && (count_value == TOP_8BIT) |=> count_value == CNT_BOTTOM;
   endproperty
   a_top5: assert property (p_top5)
      else $error("count did not restart at fixed top");
   property p_excl;
      !(wr && rd);
   endproperty
   a_excl: assert property (p_excl)
      else $error("read and write strobes together");
   property p_wr_pulse;
      wr |=> !wr;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe longer than one cycle");
   property p_rd_pulse;
      $rose(rd) |=> $fell(rd);
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe longer than one cycle");
   c_lo_write: cover property (cnt_wr);
   c_hi_read: cover property (rd && (addr == A_CNT_HI));
   c_top5: cover property (run5 && (count_value == TOP_8BIT));
endmodule

// File: bench/tb_top.sv
// Purpose: self-checking bench for timer controller and core
// Assumes: AHB-Lite master in the bench, zero-wait slave
// Notes: every timer access goes through the controller
`timescale 1ns/1ns
module tb_top
   import tmr_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic ext_pin = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] presc_tick = 4'h0;
   logic [2:0] force_seen = 3'h0;
   logic [15:0] rv;
   wire logic hready;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic [15:0] count_value;
   wire logic count_down, count_top, count_bottom, irq;
   wire logic [3:0] wave_mode;
   wire logic [2:0] cmp_match, force_cmp;
   wire logic [1:0] cmp_c_out_mode;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   always #50 hclk = ~hclk;
   tmr_bus_if bus_if();
   tmr_host i_tmr_host(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .bus(bus_if.host));
   tmr_dev i_tmr_dev(.hclk(hclk), .hresetn(hresetn), .bus(bus_if.dev), .presc_tick(presc_tick),
      .ext_pin(ext_pin), .count_value(count_value), .count_down(count_down), .count_top(count_top),
      .count_bottom(count_bottom), .wave_mode(wave_mode), .cmp_match(cmp_match),
      .force_cmp(force_cmp), .cmp_c_out_mode(cmp_c_out_mode), .irq(irq));
   tmr_bus_checker i_tmr_bus_checker(.hclk(hclk), .hresetn(hresetn), .addr(bus_if.addr),
      .wr(bus_if.wr), .rd(bus_if.rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
      .count_value(count_value));
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Pulses are gone before any poll ends
   always @(posedge hclk)
   begin
      force_seen <= force_seen | force_cmp;
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         report_and_stop;
      end
   end
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   // One timer access; waits for done, then clears it
   task automatic op(input logic [3:0] a, input logic w, input logic wide, input logic [15:0] d);
      logic [31:0] x;
      if (w)
         ahb(H_WDATA, 1'b1, {16'h0, d}, x);
      ahb(H_CMD, 1'b1, {26'h0, wide, w, a}, x);
      do ahb(H_STATUS, 1'b0, 32'h0, x); while (x[B_ST_DONE] !== 1'b1);
      ahb(H_STATUS, 1'b1, 32'h1, x);
      ahb(H_RDATA, 1'b0, 32'h0, x);
      // Narrow reads fill the low byte only
      rv = wide ? x[15:0] : {8'h00, x[7:0]};
   endtask
   task s_reset;
      op(A_CNT_LO, 1'b0, 1'b1, 16'h0);
      check("count after reset", rv, 16'h0);
      check("bottom at zero", count_bottom, 1'b1);
      check("wave mode reset", wave_mode, 4'h0);
      check("okay response", hresp, 1'b0);
   endtask
   // Reset in mid-run must clear count and holding byte
   task s_rst2;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      check("count after second reset", count_value, 16'h0);
      op(A_CNT_HI, 1'b0, 1'b0, 16'h0);
      check("holding after second reset", rv, 16'h0);
   endtask
   task s_wide;
      op(A_CNT_LO, 1'b1, 1'b1, 16'h01ff);
      check("count port", count_value, 16'h01ff);
      op(A_CNT_LO, 1'b0, 1'b1, 16'h0);
      check("wide read", rv, 16'h01ff);
      check("bottom cleared", count_bottom, 1'b0);
   endtask
   task s_hold;
      op(A_CMPA_HI, 1'b1, 1'b0, 16'h5a);
      op(A_CMPA_LO, 1'b1, 1'b0, 16'h11);
      op(A_CMPB_LO, 1'b1, 1'b0, 16'h22);
      op(A_CMPB_HI, 1'b0, 1'b0, 16'h0);
      check("shared high byte", rv, 16'h5a);
      op(A_CMPA_LO, 1'b0, 1'b0, 16'h0);
      check("compare low direct", rv, 16'h11);
      op(A_CNT_HI, 1'b0, 1'b0, 16'h0);
      check("holding after compare reads", rv, 16'h5a);
   endtask
   task s_run;
      logic [15:0] v;
      op(A_CNT_LO, 1'b1, 1'b1, 16'hfff0);
      op(A_MASK, 1'b1, 1'b0, 16'h1);
      op(A_CTRL_B, 1'b1, 1'b0, 16'h1);
      repeat (30) @(posedge hclk);
      op(A_CTRL_B, 1'b0 | 1'b1, 1'b0, 16'h0);
      v = count_value;
      repeat (5) @(posedge hclk);
      check("stopped count", count_value, v);
      check("count wrapped", count_value < 16'h0080, 1'b1);
      check("irq raised", irq, 1'b1);
      op(A_MASK, 1'b1, 1'b0, 16'h0);
      check("irq masked", irq, 1'b0);
      op(A_FLAGS, 1'b1, 1'b0, 16'h1);
      op(A_FLAGS, 1'b0, 1'b0, 16'h0);
      check("overflow cleared", rv[B_TOV], 1'b0);
   endtask
   // Fast slope, then dual slope on the same fixed top
   task s_top;
      logic over;
      logic top_seen;
      logic down_seen;
      logic [2:0] match_seen;
      over = 1'b0;
      top_seen = 1'b0;
      down_seen = 1'b0;
      match_seen = 3'h0;
      op(A_CNT_LO, 1'b1, 1'b1, 16'h00f0);
      op(A_CTRL_A, 1'b1, 1'b0, 16'h0d);
      op(A_CTRL_B, 1'b1, 1'b0, 16'h09);
      check("wave mode", wave_mode, 4'h5);
      check("channel c mode", cmp_c_out_mode, 2'h3);
      for (int m = 0; m < 2; m++)
      begin
         repeat (600)
         begin
            @(posedge hclk);
            if (count_value > TOP_8BIT)
               over = 1'b1;
            if (count_top === 1'b1)
               top_seen = 1'b1;
            if (count_down === 1'b1)
               down_seen = 1'b1;
            match_seen = match_seen | cmp_match;
         end
         // First pass clears the upper wave-mode bits (mode 1), second stops
         op(A_CTRL_B, 1'b1, 1'b0, 16'h01 >> m);
      end
      op(A_CTRL_A, 1'b1, 1'b0, 16'h0);
      check("count above fixed top", over, 1'b0);
      check("top indication", top_seen, 1'b1);
      check("count turned down", down_seen, 1'b1);
      check("compare matches at zero", match_seen, 3'h7);
   endtask
   task s_force;
      op(A_CTRL_C, 1'b1, 1'b0, 16'he0);
      check("force pulses", force_seen, 3'h7);
   endtask
   // Wrong-source ticks and opposite ext edges must not count
   task s_src;
      logic [3:0] oh;
      for (int s = 2; s < 8; s++)
      begin
         oh = 4'h1 << (s - 2);
         op(A_CNT_LO, 1'b1, 1'b1, 16'h0);
         op(A_CTRL_B, 1'b1, 1'b0, 16'(s));
         repeat (4)
         begin
            @(posedge hclk);
            presc_tick <= ~oh;
            ext_pin <= ~ext_pin;
            @(posedge hclk);
            presc_tick <= oh;
            @(posedge hclk);
            presc_tick <= 4'h0;
            repeat (3) @(posedge hclk);
         end
         repeat (6) @(posedge hclk);
         op(A_CTRL_B, 1'b1, 1'b0, 16'h0);
         check("ticks counted", count_value, (s < 6) ? 16'h4 : 16'h2);
      end
   endtask
   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      s_reset;
      s_wide;
      s_hold;
      s_rst2;
      s_run;
      s_top;
      s_force;
      s_src;
      report_and_stop;
   end
endmodule
